// ===== hdl/pmc_top.sv
// Summary of operation
// RULE1: Two global bits pick one of three modes.
// RULE2: Per-cell polarity bit in every mode.
// RULE3: Per-cell bits pick input use, drive type.
// RULE4: Two global plus 24 cell bits configure outputs.
// RULE5: Registered: first pin clock, last pin enable.
// RULE6: Registered cells share clock and enable pins.
// RULE7: Registered: eight registers or eight I/Os.
// RULE8: Registered sums eight terms, I/O seven.
// RULE9: Complex: clock/enable pins take outer feedback.
// RULE10: Complex: seven terms plus one enable term.
// RULE11: Complex: at most six cells are I/O.
// RULE12: Simple: input or always-on eight-term output.
// RULE13: Simple: feedback via neighbour, inner cells output.
// RULE14: Simple/complex: clock and enable pins feed array.
// RULE15: Totem-pole default, open drain selectable.
// RULE16: Registers cleared at reset, preloadable.
// RULE17: Disabled terms drop out of sums.
// RULE18: Registers sample on clock pin rising edge.
// RULE19: Enable pin high floats registered outputs.
// RULE20: Open drain drives low, releases for one.
module pmc_top (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic [8:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  input  wire logic [pmc_pkg::NIN-1:0]  in_pin,
  input  wire logic                     clk_pin,
  input  wire logic                     oe_n_pin,
  input  wire logic [pmc_pkg::NCELL-1:0] io_i,
  output logic      [pmc_pkg::NCELL-1:0] io_o,
  output logic      [pmc_pkg::NCELL-1:0] io_oe
);

  localparam int NC = pmc_pkg::NCELL;
  localparam int TC = pmc_pkg::TERMS_CELL;

  logic [31:0]               cfg_q;
  logic [31:0]               tdis_lo_q;
  logic [31:0]               tdis_hi_q;
  logic [31:0]               term_q [pmc_pkg::NTERM];
  logic [31:0]               rdata_d;
  logic [pmc_pkg::NTERM-1:0] tdis;
  logic [pmc_pkg::NTERM-1:0] term_hit;
  logic [pmc_pkg::ARR_W-1:0] arr_in;
  logic [NC-1:0]             fb;
  logic [NC-1:0]             reg_q;
  logic [NC-1:0]             io_sel_vec;
  logic                      clk_prev_q;
  logic                      clk_edge;
  logic                      pl_wr;
  logic                      term_sel;
  logic [pmc_pkg::TERM_IDX_W-1:0] term_idx;
  pmc_pkg::pmc_mode_t        mode;
  pmc_pkg::pmc_pins_t        pins_raw;
  pmc_pkg::pmc_pins_t        pins;
  pmc_pkg::pmc_cell_cfg_t    cell_cfg [NC];

  // Every pin arrives asynchronously, so all of them share one filter
  assign pins_raw.oe_n_pin = oe_n_pin;
  assign pins_raw.clk_pin  = clk_pin;
  assign pins_raw.in_pin   = in_pin;
  assign pins_raw.io_i     = io_i;

  pmc_sync #(
    .W ($bits(pmc_pkg::pmc_pins_t))
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (pins_raw),
    .lvl   (pins)
  );

  // Register port decode
  assign term_sel = reg_addr[pmc_pkg::ADDR_TERM_BIT];
  assign term_idx = reg_addr[pmc_pkg::ADDR_IDX_LSB +: pmc_pkg::TERM_IDX_W];
  assign pl_wr    = reg_wr && (reg_addr == pmc_pkg::ADDR_PRELOAD);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q     <= pmc_pkg::CFG_RST;                            // [RULE4] [RULE15]
      tdis_lo_q <= pmc_pkg::TDIS_RST;
      tdis_hi_q <= pmc_pkg::TDIS_RST;
    end else if (ce && reg_wr && !term_sel) begin
      if (reg_addr == pmc_pkg::ADDR_CFG) begin
        cfg_q <= reg_wdata;                                     // [RULE4]
      end
      if (reg_addr == pmc_pkg::ADDR_TDIS_LO) begin
        tdis_lo_q <= reg_wdata;                                 // [RULE17]
      end
      if (reg_addr == pmc_pkg::ADDR_TDIS_HI) begin
        tdis_hi_q <= reg_wdata;                                 // [RULE17]
      end
    end
  end

  // Array cells clear to empty masks; all terms start disabled instead
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int t = 0; t < pmc_pkg::NTERM; t++) begin
        term_q[t] <= pmc_pkg::TERM_RST;
      end
    end else if (ce && reg_wr && term_sel) begin
      term_q[term_idx] <= reg_wdata;
    end
  end

  assign tdis = {tdis_hi_q, tdis_lo_q};

  // Mode bits: 11 registered, 10 complex, 01 simple
  always_comb begin
    unique case ({cfg_q[pmc_pkg::CFG_SEL_A_BIT], cfg_q[pmc_pkg::CFG_SEL_B_BIT]})
      2'b11:   mode = pmc_pkg::PMC_MODE_REG;                    // [RULE1]
      2'b10:   mode = pmc_pkg::PMC_MODE_CPLX;                   // [RULE1]
      2'b01:   mode = pmc_pkg::PMC_MODE_SIMPLE;                 // [RULE1]
      default: mode = pmc_pkg::PMC_MODE_SIMPLE;
    endcase
  end

  genvar gc;
  generate
    for (gc = 0; gc < NC; gc++) begin : g_cfg
      assign cell_cfg[gc]   = pmc_pkg::pmc_cell_cfg_t'(
          cfg_q[pmc_pkg::CFG_CELL_LSB + pmc_pkg::CELL_CFG_W * gc +: pmc_pkg::CELL_CFG_W]);
      assign io_sel_vec[gc] = cell_cfg[gc].cell_io_select_bit;
    end
  endgenerate

  // Feedback routing per mode
  always_comb begin
    fb = pins.io_i;
    for (int k = 0; k < NC; k++) begin
      unique case (mode)
        pmc_pkg::PMC_MODE_REG: begin
          fb[k] = io_sel_vec[k] ? pins.io_i[k] : reg_q[k];     // [RULE5] [RULE7]
        end
        pmc_pkg::PMC_MODE_CPLX: begin
          if (k == pmc_pkg::SLOT_OUTER_LO) begin
            fb[k] = pins.clk_pin;                               // [RULE9] [RULE14]
          end else if (k == pmc_pkg::SLOT_OUTER_HI) begin
            fb[k] = pins.oe_n_pin;                              // [RULE9] [RULE14]
          end else begin
            fb[k] = pins.io_i[k];                               // [RULE11]
          end
        end
        pmc_pkg::PMC_MODE_SIMPLE: begin
          if (k == pmc_pkg::SLOT_OUTER_LO) begin
            fb[k] = pins.clk_pin;                               // [RULE14]
          end else if (k == pmc_pkg::SLOT_OUTER_HI) begin
            fb[k] = pins.oe_n_pin;                              // [RULE14]
          end else if (k <= pmc_pkg::SLOT_INNER_LO) begin
            fb[k] = pins.io_i[3'(k - 1)];                       // [RULE13]
          end else begin
            fb[k] = pins.io_i[3'(k + 1)];                       // [RULE13]
          end
        end
      endcase
    end
  end

  // Columns interleave one dedicated input with one feedback
  always_comb begin
    for (int k = 0; k < pmc_pkg::NIN; k++) begin
      arr_in[2 * k]     = pins.in_pin[k];
      arr_in[2 * k + 1] = fb[k];
    end
  end

  // An empty mask makes a term true; disable cells keep it out of sums
  always_comb begin
    for (int t = 0; t < pmc_pkg::NTERM; t++) begin
      term_hit[t] = &((~term_q[t][pmc_pkg::TM_TRUE_LSB +: pmc_pkg::ARR_W] | arr_in)
                    & (~term_q[t][pmc_pkg::TM_COMP_LSB +: pmc_pkg::ARR_W] | ~arr_in));
    end
  end

  // Edge taken from the filtered level, so a glitch cannot clock twice
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b1;
    end else if (ce) begin
      clk_prev_q <= pins.clk_pin;
    end
  end

  assign clk_edge = pins.clk_pin && !clk_prev_q;                // [RULE18]

  genvar gk;
  generate
    for (gk = 0; gk < NC; gk++) begin : g_cell
      pmc_cell #(
        .OUTER (gk == pmc_pkg::SLOT_OUTER_LO || gk == pmc_pkg::SLOT_OUTER_HI),
        .INNER (gk == pmc_pkg::SLOT_INNER_LO || gk == pmc_pkg::SLOT_INNER_HI)
      ) u_cell (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .mode     (mode),
        .cfg      (cell_cfg[gk]),
        .terms    (term_hit[gk * TC +: TC]),
        .tdis     (tdis[gk * TC +: TC]),
        .oe_lvl   (pins.oe_n_pin),
        .clk_edge (clk_edge),
        .pl_wr    (pl_wr),
        .pl_val   (reg_wdata[gk]),
        .pin_o    (io_o[gk]),
        .pin_oe   (io_oe[gk]),
        .reg_q    (reg_q[gk])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (term_sel) begin
      rdata_d = term_q[term_idx];
    end else begin
      unique case (reg_addr)
        pmc_pkg::ADDR_CFG:     rdata_d = cfg_q;
        pmc_pkg::ADDR_TDIS_LO: rdata_d = tdis_lo_q;
        pmc_pkg::ADDR_TDIS_HI: rdata_d = tdis_hi_q;
        pmc_pkg::ADDR_PRELOAD: rdata_d[NC-1:0] = reg_q;
        pmc_pkg::ADDR_STATUS: begin
          rdata_d[pmc_pkg::ST_PIN_LSB +: NC] = pins.io_i;
          rdata_d[pmc_pkg::ST_REG_LSB +: NC] = reg_q;
          rdata_d[pmc_pkg::ST_CLK_BIT]       = pins.clk_pin;
          rdata_d[pmc_pkg::ST_OE_BIT]        = pins.oe_n_pin;
          rdata_d[pmc_pkg::ST_MODE_LSB +: 2] = mode;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  // Data stands for exactly the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rdata_d : '0;
    end
  end

  property p_oe_float;
    @(posedge clk) disable iff (!rst_n)
    ce && mode == pmc_pkg::PMC_MODE_REG && pins.oe_n_pin |=> (io_oe & ~$past(io_sel_vec)) == '0;
  endproperty
  a_oe_float: assert property (p_oe_float) else $error("registered output drove while disabled"); // [RULE19]

  property p_oe_keeps;
    @(posedge clk) disable iff (!rst_n)
    ce && pins.oe_n_pin && !pl_wr && !clk_edge |=> reg_q == $past(reg_q);
  endproperty
  a_oe_keeps: assert property (p_oe_keeps) else $error("register lost contents"); // [RULE19]

  property p_por;
    @(posedge clk) $rose(rst_n) |-> reg_q == '0 && io_oe == '0;
  endproperty
  a_por: assert property (p_por) else $error("registers not cleared at reset"); // [RULE16]

  property p_preload;
    @(posedge clk) disable iff (!rst_n)
    ce && pl_wr |=> reg_q == $past(reg_wdata[NC-1:0]);
  endproperty
  a_preload: assert property (p_preload) else $error("preload value not taken"); // [RULE16]

  property p_cplx_fb;
    @(posedge clk) disable iff (!rst_n)
    mode == pmc_pkg::PMC_MODE_CPLX |->
      arr_in[2 * pmc_pkg::SLOT_OUTER_LO + 1] == pins.clk_pin
      && arr_in[2 * pmc_pkg::SLOT_OUTER_HI + 1] == pins.oe_n_pin;
  endproperty
  a_cplx_fb: assert property (p_cplx_fb) else $error("complex feedback not from pins"); // [RULE9]

  property p_simple_inner;
    @(posedge clk) disable iff (!rst_n)
    ce && mode == pmc_pkg::PMC_MODE_SIMPLE
      && !cell_cfg[pmc_pkg::SLOT_INNER_LO].cell_drive_type_bit
      |=> io_oe[pmc_pkg::SLOT_INNER_LO];
  endproperty
  a_simple_inner: assert property (p_simple_inner) else $error("inner cell not driving"); // [RULE13]

  property p_rdata_pulse;
    @(posedge clk) disable iff (!rst_n)
    ce && !reg_rd |=> reg_rdata == '0;
  endproperty
  a_rdata_pulse: assert property (p_rdata_pulse) else $error("read data outside its cycle");

  property p_cplx_oe;
    @(posedge clk) disable iff (!rst_n)
    ce && mode == pmc_pkg::PMC_MODE_CPLX && tdis[pmc_pkg::OE_TERM]
      |=> !io_oe[pmc_pkg::SLOT_OUTER_LO];
  endproperty
  a_cplx_oe: assert property (p_cplx_oe) else $error("enable term ignored"); // [RULE10]

  property p_cv_clock;
    @(posedge clk) disable iff (!rst_n)
    mode == pmc_pkg::PMC_MODE_REG && clk_edge && ce;
  endproperty
  c_cv_clock: cover property (p_cv_clock);

  property p_cv_preload;
    @(posedge clk) disable iff (!rst_n)
    pl_wr && ce ##1 reg_rd;
  endproperty
  c_cv_preload: cover property (p_cv_preload);

  property p_cv_cplx;
    @(posedge clk) disable iff (!rst_n)
    mode == pmc_pkg::PMC_MODE_CPLX && io_oe != '0;
  endproperty
  c_cv_cplx: cover property (p_cv_cplx);

  property p_cv_simple;
    @(posedge clk) disable iff (!rst_n)
    mode == pmc_pkg::PMC_MODE_SIMPLE && io_oe == '1;
  endproperty
  c_cv_simple: cover property (p_cv_simple);

endmodule

// ===== hdl/pmc_pkg.sv
package pmc_pkg;

  localparam int NCELL      = 8;
  localparam int NIN        = 8;
  localparam int ARR_W      = 2 * NIN;
  localparam int TERMS_CELL = 8;
  localparam int NTERM      = NCELL * TERMS_CELL;
  localparam int CELL_CFG_W = 3;

  localparam logic [8:0] ADDR_CFG       = 9'h000;
  localparam logic [8:0] ADDR_TDIS_LO   = 9'h004;
  localparam logic [8:0] ADDR_TDIS_HI   = 9'h008;
  localparam logic [8:0] ADDR_PRELOAD   = 9'h00C;
  localparam logic [8:0] ADDR_STATUS    = 9'h010;
  localparam int         ADDR_TERM_BIT  = 8;
  localparam int         ADDR_IDX_LSB   = 2;
  localparam int         TERM_IDX_W     = 6;

  localparam int CFG_SEL_A_BIT = 0;
  localparam int CFG_SEL_B_BIT = 1;
  localparam int CFG_CELL_LSB  = 8;
  localparam logic [31:0] CFG_RST  = 32'h4924_9200;
  localparam logic [31:0] TDIS_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] TERM_RST = 32'h0000_0000;

  localparam int TM_TRUE_LSB = 0;
  localparam int TM_COMP_LSB = 16;

  localparam int ST_PIN_LSB  = 0;
  localparam int ST_REG_LSB  = 8;
  localparam int ST_CLK_BIT  = 16;
  localparam int ST_OE_BIT   = 17;
  localparam int ST_MODE_LSB = 18;

  localparam int SLOT_OUTER_LO = 0;
  localparam int SLOT_INNER_LO = 3;
  localparam int SLOT_INNER_HI = 4;
  localparam int SLOT_OUTER_HI = 7;
  localparam int OE_TERM       = 0;

  typedef enum logic [1:0] {
    PMC_MODE_REG,
    PMC_MODE_CPLX,
    PMC_MODE_SIMPLE
  } pmc_mode_t;

  typedef struct packed {
    logic cell_drive_type_bit;
    logic cell_io_select_bit;
    logic pol_invert;
  } pmc_cell_cfg_t;

  typedef struct packed {
    logic             oe_n_pin;
    logic             clk_pin;
    logic [NIN-1:0]   in_pin;
    logic [NCELL-1:0] io_i;
  } pmc_pins_t;

endpackage

// ===== hdl/pmc_sync.sv
module pmc_sync #(
  parameter int W = 18
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Reset level is high to match the pin pull-ups
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once two settled stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl <= '1;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ===== hdl/pmc_cell.sv
module pmc_cell #(
  parameter bit OUTER = 1'b0,
  parameter bit INNER = 1'b0
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire pmc_pkg::pmc_mode_t            mode,
  input  wire pmc_pkg::pmc_cell_cfg_t        cfg,
  input  wire logic [pmc_pkg::TERMS_CELL-1:0] terms,
  input  wire logic [pmc_pkg::TERMS_CELL-1:0] tdis,
  input  wire logic                          oe_lvl,
  input  wire logic                          clk_edge,
  input  wire logic                          pl_wr,
  input  wire logic                          pl_val,
  output logic                               pin_o,
  output logic                               pin_oe,
  output logic                               reg_q
);

  logic [pmc_pkg::TERMS_CELL-1:0] act;
  logic                           sum_all;
  logic                           sum_io;
  logic                           sum;
  logic                           en;
  logic                           val;
  logic                           is_reg;

  assign act     = terms & ~tdis;                               // [RULE17]
  assign sum_all = |act;
  assign sum_io  = |act[pmc_pkg::TERMS_CELL-1:pmc_pkg::OE_TERM+1];
  assign is_reg  = (mode == pmc_pkg::PMC_MODE_REG) && !cfg.cell_io_select_bit;

  always_comb begin
    sum = sum_all;
    en  = 1'b0;
    unique case (mode)
      pmc_pkg::PMC_MODE_REG: begin
        if (is_reg) begin
          sum = sum_all;                                        // [RULE8]
          en  = !oe_lvl;                                        // [RULE6] [RULE19]
        end else begin
          sum = sum_io;                                         // [RULE8]
          en  = act[pmc_pkg::OE_TERM];                          // [RULE7]
        end
      end
      pmc_pkg::PMC_MODE_CPLX: begin
        sum = sum_io;                                           // [RULE10]
        en  = act[pmc_pkg::OE_TERM];                            // [RULE10] [RULE11]
      end
      pmc_pkg::PMC_MODE_SIMPLE: begin
        sum = sum_all;                                          // [RULE12]
        en  = INNER ? 1'b1 : !cfg.cell_io_select_bit;           // [RULE12] [RULE13]
      end
    endcase
  end

  assign val = (is_reg ? reg_q : sum) ^ cfg.pol_invert;         // [RULE2]

  // Power-on clear, then preload beats the pin clock so tests set any state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_q <= 1'b0;                                            // [RULE16]
    end else if (ce) begin
      if (pl_wr) begin
        reg_q <= pl_val;                                        // [RULE16]
      end else if (is_reg && clk_edge) begin
        reg_q <= sum;                                           // [RULE18]
      end
    end
  end

  // Open drain only ever pulls low; a one releases the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ce) begin
      pin_o  <= cfg.cell_drive_type_bit ? 1'b0 : val;           // [RULE3] [RULE15] [RULE20]
      pin_oe <= en && (!cfg.cell_drive_type_bit || !val);       // [RULE20]
    end
  end

  property p_capture;
    @(posedge clk) disable iff (!rst_n)
    ce && clk_edge && !pl_wr && is_reg |=> reg_q == $past(sum);
  endproperty
  a_capture: assert property (p_capture) else $error("register missed clock edge"); // [RULE18]

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    ce && !clk_edge && !pl_wr |=> $stable(reg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without edge"); // [RULE18]

  property p_open_drain;
    @(posedge clk) disable iff (!rst_n)
    ce && cfg.cell_drive_type_bit |=> !(pin_oe && pin_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // [RULE20]

  property p_all_off;
    @(posedge clk) disable iff (!rst_n)
    ce && (tdis == '1) && (mode == pmc_pkg::PMC_MODE_SIMPLE) && !cfg.cell_drive_type_bit
      |=> pin_o == $past(cfg.pol_invert);
  endproperty
  a_all_off: assert property (p_all_off) else $error("disabled terms reached output"); // [RULE17]

endmodule

// ===== dv/pmc_pin_model.sv
// Far side of the macrocell pins: a pull-up on every pin, plus an
// optional outside driver for pins that the block uses as inputs.
module pmc_pin_model (
  input  wire logic [pmc_pkg::NCELL-1:0] io_o,
  input  wire logic [pmc_pkg::NCELL-1:0] io_oe,
  input  wire logic [pmc_pkg::NCELL-1:0] ext_en,
  input  wire logic [pmc_pkg::NCELL-1:0] ext_val,
  output logic      [pmc_pkg::NCELL-1:0] io_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Released pin with no outside driver reads high; the block wins over the outside driver
  always_comb begin
    for (int k = 0; k < pmc_pkg::NCELL; k++) begin
      io_i[k] = io_oe[k] ? io_o[k] : (ext_en[k] ? ext_val[k] : 1'b1);
    end
  end
endmodule

// ===== dv/pmc_top_tb.sv
module pmc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst_n, ce, reg_wr, reg_rd, clk_pin, oe_n_pin;
  logic [8:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [7:0]  in_pin, io_i, io_o, io_oe, ext_en, ext_val, eo, ee;
  logic [23:0] cells;
  logic        v;
  int          fail_count, compares, t;
  logic [31:0] mem [int];

  pmc_top u_pmc_top (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_pin(in_pin), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_i(io_i),
    .io_o(io_o), .io_oe(io_oe));
  pmc_pin_model u_pmc_pin_model (.io_o(io_o), .io_oe(io_oe), .ext_en(ext_en),
    .ext_val(ext_val), .io_i(io_i));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task stop_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk_rd(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task chk_pin(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m,
               input string what);
    compares++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Model of the register file; only a write taken with ce high lands
  task wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (ce === 1'b1 && (a == 9'h000 || a == 9'h004 || a == 9'h008 || a >= 9'h100))
      mem[a] = d;
    if (ce === 1'b1 && a == 9'h00C) mem[a] = {24'h000000, d[7:0]};
  endtask

  task rd(input logic [8:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task rd_chk(input logic [8:0] a);
    rd(a);
    chk_rd(rd_val, mem.exists(a) ? mem[a] : 32'h0000_0000, "register read");
  endtask

  task init_mem;
    mem.delete();
    mem[0] = pmc_pkg::CFG_RST;
    mem[4] = pmc_pkg::TDIS_RST;
    mem[8] = pmc_pkg::TDIS_RST;
    mem[12] = 32'h0000_0000;
    for (int i = 0; i < 64; i++) mem[256 + 4 * i] = pmc_pkg::TERM_RST;
  endtask

  // Pins pass a filter, so wait out its latency with some margin
  task settle;
    repeat (10) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, clk_pin, oe_n_pin, reg_addr, reg_wdata} = '0;
    {in_pin, ext_en, ext_val} = '0;
    ce = 1'b1;
    init_mem;
    void'($urandom(32'h975cb4d4));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_pin(io_oe, 8'h00, 8'hFF, "reset enables");
    @(posedge clk);
    #1;
    chk_pin(io_oe, 8'h18, 8'hFF, "inner cells after reset");
    foreach (mem[a]) if (a < 20 || a == 256 || a == 508) rd_chk(a[8:0]);
    rd_chk(9'h014);
    rd(pmc_pkg::ADDR_STATUS);
    chk_rd({30'h0, rd_val[19:18]}, 32'h2, "reset mode");
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      t = $urandom_range(63);
      wr(9'(256 + 4 * t), $urandom);
      rd_chk(9'(256 + 4 * t));
    end
    @(posedge clk);
    ce <= 1'b0;
    wr(pmc_pkg::ADDR_CFG, 32'h0000_0003);
    ce <= 1'b1;
    rd_chk(pmc_pkg::ADDR_CFG);
    $display("test register file done");

    // Simple mode: cell 3 sums in_pin[0] and the neighbour feedback of pin 0
    wr(pmc_pkg::ADDR_TDIS_LO, ~(32'h3 << 24));
    wr(9'h160, 32'h0000_0001);
    wr(9'h164, 32'h0000_0008);
    ext_en <= 8'h01;
    for (int pd = 0; pd < 4; pd++) begin
      cells = 24'h492492;
      cells[11:9] = {pd[1], 1'b0, pd[0]};
      wr(pmc_pkg::ADDR_CFG, {cells, 6'h00, 2'b10});
      for (int j = 0; j < 3; j++) begin
        @(posedge clk);
        in_pin  <= 8'($urandom);
        ext_val <= 8'($urandom);
        settle;
        v  = (in_pin[0] | ext_val[0]) ^ pd[0];
        ee = {3'b000, 1'b1, pd[1] ? ~v : 1'b1, 3'b000};
        eo = {4'h0, pd[1] ? 1'b0 : v, 3'b000};
        chk_pin(io_oe, ee, 8'hFF, "simple enables");
        chk_pin(io_o, eo, ee, "simple values");
      end
    end
    ext_en <= 8'h00;
    $display("test simple mode done");

    // Registered mode: cell 0 registers in_pin[0], output inverted
    wr(pmc_pkg::ADDR_TDIS_LO, 32'hFFFF_FFFE);
    wr(9'h100, 32'h0000_0001);
    wr(pmc_pkg::ADDR_PRELOAD, 32'h0000_0000);
    wr(pmc_pkg::ADDR_CFG, {24'h492491, 6'h00, 2'b11});
    oe_n_pin <= 1'b0;
    in_pin   <= 8'h01;
    settle;
    chk_pin(io_oe, 8'h01, 8'hFF, "registered enables");
    chk_pin(io_o, 8'h01, 8'h01, "inverted before edge");
    rd_chk(pmc_pkg::ADDR_PRELOAD);
    @(posedge clk) clk_pin <= 1'b1;
    repeat (5) @(posedge clk);
    clk_pin <= 1'b0;
    settle;
    mem[12] = 32'h0000_0001;
    rd_chk(pmc_pkg::ADDR_PRELOAD);
    chk_pin(io_o, 8'h00, 8'h01, "registered value");
    @(posedge clk);
    in_pin <= 8'h00;
    oe_n_pin <= 1'b1;
    settle;
    chk_pin(io_oe, 8'h00, 8'hFF, "shared enable off");
    rd_chk(pmc_pkg::ADDR_PRELOAD);
    wr(pmc_pkg::ADDR_PRELOAD, 32'h0000_00A5);
    rd_chk(pmc_pkg::ADDR_PRELOAD);
    $display("test registered mode done");

    // Complex mode: cell 1 enabled by term 8, its value is the clock pin
    wr(pmc_pkg::ADDR_TDIS_LO, 32'hFFFF_FCFF);
    wr(9'h120, 32'h0000_0000);
    wr(9'h124, 32'h0000_0002);
    wr(pmc_pkg::ADDR_CFG, {24'h492482, 6'h00, 2'b01});
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      clk_pin <= j[0];
      settle;
      chk_pin(io_oe, 8'h02, 8'hFF, "complex enables");
      chk_pin(io_o, {6'h00, j[0], 1'b0}, 8'h02, "complex value");
    end
    wr(pmc_pkg::ADDR_TDIS_LO, 32'hFFFF_FDFF);
    settle;
    chk_pin(io_oe, 8'h00, 8'hFF, "enable term off");
    $display("test complex mode done");

    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    init_mem;
    #1;
    chk_pin(io_oe, 8'h00, 8'hFF, "second reset");
    @(posedge clk);
    #1;
    chk_pin(io_oe, 8'h18, 8'hFF, "inner cells after second reset");
    rd_chk(pmc_pkg::ADDR_CFG);
    rd_chk(pmc_pkg::ADDR_PRELOAD);
    $display("test second reset done");
    stop_test;
  end
endmodule
